// ==== src/config_startup_sequencer.sv ====
// Startup phase sequencer run after configuration load
//
// Functional notes
// RULE1: Write enable asserts at selected phase
// RULE2: Block RAM enabled only with write enable
// RULE3: Hold at lock phase until all locked
// RULE4: No-wait lock setting never stalls on lock
// RULE5: Stall at match phase until calibration matched
// RULE6: Match phase only checks, never starts calibration
// RULE7: Auto match uses phase 2 if calibrated
// RULE8: Source keeps config clock until done high
// RULE9: One phase per tick; stay while stalled
module config_startup_sequencer (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       configLoaded,
    input  wire logic       cfgClockTick,
    input  wire logic [3:0] writeEnablePhaseSelect,
    input  wire logic [3:0] lockWaitPhaseSelect,
    input  wire logic [3:0] matchWaitPhaseSelect,
    input  wire logic [2:0] donePhaseSelect,
    input  wire logic       usesCalibratedIo,
    input  wire logic       allClocksLocked,
    input  wire logic       impedanceCalibrationMatched,
    output logic [2:0]      startupPhase,
    output logic            globalWriteEnable,
    output logic            blockRamEnable,
    output logic            done,
    output logic            stalled
);

    ////////////////////////////////////////////////////////////////////////
    // State

    startup_seq_pkg::seq_s state_q;
    startup_seq_pkg::seq_s state_d;

    logic       lockHold;
    logic       matchHold;
    logic [3:0] matchEffSelect;
    logic       running;
    logic       doneReached;
    logic       weReached;

    assign running = (state_q.fsm == startup_seq_pkg::SEQ_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Wait conditions

    // Auto resolves to phase 2 only when calibrated I/O is present
    always_comb begin
        if (matchWaitPhaseSelect == startup_seq_pkg::WAIT_SEL_AUTO) begin
            matchEffSelect = usesCalibratedIo ?
                startup_seq_pkg::MATCH_AUTO_PHASE :
                startup_seq_pkg::WAIT_SEL_NO_WAIT_OPTION; // see RULE7
        end else begin
            matchEffSelect = matchWaitPhaseSelect;
        end
    end

    // No-wait code is out of the 0..6 range, so it never holds
    phase_wait_check u_lock_wait (
        .waitSelect   (lockWaitPhaseSelect),
        .phase        (state_q.phase),
        .conditionMet (allClocksLocked),
        .hold         (lockHold)
    ); // see RULE3 see RULE4

    // Calibration runs on its own; this only samples its match flag
    phase_wait_check u_match_wait (
        .waitSelect   (matchEffSelect),
        .phase        (state_q.phase),
        .conditionMet (impedanceCalibrationMatched),
        .hold         (matchHold)
    ); // see RULE5 see RULE6

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_d     = state_q;
        doneReached = (state_q.phase >= donePhaseSelect);
        weReached   = 1'b0;
        case (state_q.fsm)
            startup_seq_pkg::SEQ_IDLE: begin
                if (configLoaded) begin
                    state_d.fsm   = startup_seq_pkg::SEQ_RUN;
                    state_d.phase = startup_seq_pkg::FIRST_PHASE;
                end
            end
            startup_seq_pkg::SEQ_RUN: begin
                // A stall freezes the phase even while ticks keep coming
                if (cfgClockTick && !lockHold && !matchHold) begin
                    if (state_q.phase == startup_seq_pkg::LAST_PHASE) begin
                        state_d.fsm = startup_seq_pkg::SEQ_FINISHED;
                    end else begin
                        state_d.phase = 3'(state_q.phase + 3'h1); // see RULE9
                    end
                end
            end
            startup_seq_pkg::SEQ_FINISHED: begin
                state_d.fsm = startup_seq_pkg::SEQ_FINISHED;
            end
            default: begin
                state_d = startup_seq_pkg::SEQ_RESET;
            end
        endcase
        if (state_q.fsm == startup_seq_pkg::SEQ_IDLE) begin
            doneReached = 1'b0;
        end
        state_d.done = state_q.done || doneReached;
        // Keep never asserts; done follows the done flag
        case (writeEnablePhaseSelect)
            startup_seq_pkg::WE_SEL_DONE: weReached = state_q.done;
            startup_seq_pkg::WE_SEL_KEEP: weReached = 1'b0;
            default: begin
                weReached = (state_q.fsm != startup_seq_pkg::SEQ_IDLE) &&
                    ({1'b0, state_q.phase} >= writeEnablePhaseSelect);
            end
        endcase
        state_d.writeEnable = state_q.writeEnable || weReached; // see RULE1
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= startup_seq_pkg::SEQ_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign startupPhase      = state_q.phase;
    assign globalWriteEnable = state_q.writeEnable;
    // Block RAM stays off until write enable, never separately
    assign blockRamEnable    = state_q.writeEnable; // see RULE2
    // Stall time varies, so the source must run until done rises
    assign done              = state_q.done; // see RULE8
    assign stalled           = running && (lockHold || matchHold);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_tick_free;
        running && cfgClockTick && !lockHold && !matchHold &&
            (state_q.phase != startup_seq_pkg::LAST_PHASE);
    endsequence

    sequence s_lock_stall;
        running && lockWaitPhaseSelect <= 4'h6 &&
            lockWaitPhaseSelect[2:0] == state_q.phase && !allClocksLocked;
    endsequence

    sequence s_match_stall;
        running && matchEffSelect <= 4'h6 &&
            matchEffSelect[2:0] == state_q.phase &&
            !impedanceCalibrationMatched;
    endsequence

    property p_we_phase;
        (running && writeEnablePhaseSelect >= 4'h1 &&
            writeEnablePhaseSelect <= 4'h6 &&
            {1'b0, state_q.phase} >= writeEnablePhaseSelect)
            |=> globalWriteEnable;
    endproperty
    a_we_phase: assert property (p_we_phase) // see RULE1
        else $error("write enable missing at selected phase");

    property p_we_early;
        (running && writeEnablePhaseSelect >= 4'h1 &&
            writeEnablePhaseSelect <= 4'h6 && !globalWriteEnable &&
            {1'b0, state_q.phase} < writeEnablePhaseSelect)
            |=> !globalWriteEnable;
    endproperty
    a_we_early: assert property (p_we_early) // see RULE1
        else $error("write enable asserted before selected phase");

    // Block RAM must stay off before the selected phase and under keep
    property p_bram;
        (blockRamEnable == globalWriteEnable) &&
            !(blockRamEnable &&
              ((writeEnablePhaseSelect == startup_seq_pkg::WE_SEL_KEEP) ||
               (running && writeEnablePhaseSelect >= 4'h1 &&
                writeEnablePhaseSelect <= 4'h6 &&
                {1'b0, startupPhase} < writeEnablePhaseSelect)));
    endproperty
    a_bram: assert property (p_bram) // see RULE2
        else $error("block RAM enable differs from write enable");

    property p_lock_hold;
        s_lock_stall |-> stalled ##1 $stable(startupPhase) && running;
    endproperty
    a_lock_hold: assert property (p_lock_hold) // see RULE3
        else $error("phase moved while clocks unlocked");

    property p_no_wait_option_lock;
        (lockWaitPhaseSelect == startup_seq_pkg::WAIT_SEL_NO_WAIT_OPTION &&
            running && cfgClockTick && !matchHold &&
            state_q.phase != startup_seq_pkg::LAST_PHASE)
            |=> startupPhase == 3'($past(startupPhase) + 3'h1);
    endproperty
    a_no_wait_option_lock: assert property (p_no_wait_option_lock) // see RULE4
        else $error("no-wait lock setting stalled");

    property p_match_hold;
        s_match_stall |-> stalled ##1 $stable(startupPhase);
    endproperty
    a_match_hold: assert property (p_match_hold) // see RULE5
        else $error("phase moved before calibration match");

    property p_match_release;
        (running && matchEffSelect <= 4'h6 && !lockHold && cfgClockTick &&
            matchEffSelect[2:0] == state_q.phase &&
            impedanceCalibrationMatched &&
            state_q.phase != startup_seq_pkg::LAST_PHASE)
            |=> !$stable(startupPhase);
    endproperty
    a_match_release: assert property (p_match_release) // see RULE6
        else $error("matched calibration did not release phase");

    property p_auto_match;
        (running && !lockHold && !impedanceCalibrationMatched &&
            matchWaitPhaseSelect == startup_seq_pkg::WAIT_SEL_AUTO)
            |-> (stalled == (usesCalibratedIo && state_q.phase == 3'h2));
    endproperty
    a_auto_match: assert property (p_auto_match) // see RULE7
        else $error("auto match wait at wrong phase");

    property p_one_step;
        s_tick_free |=> startupPhase == 3'($past(startupPhase) + 3'h1);
    endproperty
    a_one_step: assert property (p_one_step) // see RULE9
        else $error("phase did not step by one");

    property p_no_tick;
        (running && !cfgClockTick) |=> $stable(startupPhase) [*1];
    endproperty
    a_no_tick: assert property (p_no_tick) // see RULE9
        else $error("phase moved without a tick");

endmodule : config_startup_sequencer

// ==== src/startup_seq_pkg.sv ====
// Constants shared by the startup sequencer files
package startup_seq_pkg;

    localparam int unsigned PHASE_W = 3;
    localparam int unsigned SEL_W   = 4;

    // Startup phases run 0 to 7; phase 7 is the last one
    localparam logic [2:0] FIRST_PHASE = 3'h0;
    localparam logic [2:0] LAST_PHASE  = 3'h7;
    localparam logic [2:0] MAX_WAIT_PHASE = 3'h6;

    // Write enable phase select: 1 to 6, done, keep
    localparam logic [3:0] WE_SEL_DONE    = 4'h7;
    localparam logic [3:0] WE_SEL_KEEP    = 4'h8;
    localparam logic [3:0] WE_SEL_DEFAULT = 4'h6;

    // Lock wait and match wait selects: 0 to 6, no wait; auto for match wait only
    localparam logic [3:0] WAIT_SEL_AUTO    = 4'he;
    localparam logic [3:0] WAIT_SEL_NO_WAIT_OPTION  = 4'hf;
    localparam logic [3:0] MATCH_AUTO_PHASE = 4'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE     = 2'b00,
        SEQ_RUN      = 2'b01,
        SEQ_FINISHED = 2'b10
    } seq_state_e;

    typedef struct packed {
        seq_state_e       fsm;
        logic [2:0]       phase;
        logic             writeEnable;
        logic             done;
    } seq_s;

    localparam seq_s SEQ_RESET = '{
        fsm:         SEQ_IDLE,
        phase:       3'h0,
        writeEnable: 1'b0,
        done:        1'b0
    };

endpackage : startup_seq_pkg

// ==== src/phase_wait_check.sv ====
// Stall decision for one wait condition at a selected phase
module phase_wait_check (
    input  wire logic [3:0] waitSelect,
    input  wire logic [2:0] phase,
    input  wire logic       conditionMet,
    output logic            hold
);

    logic selValid;

    // Values above phase 6 mean no wait, so an odd code cannot hang startup
    assign selValid = (waitSelect <= {1'b0, startup_seq_pkg::MAX_WAIT_PHASE});
    assign hold     = selValid && (waitSelect[2:0] == phase) && !conditionMet;

endmodule : phase_wait_check

// ==== dv/cfg_clock_source.sv ====
// Model of the configuration source that clocks the startup phases
module cfg_clock_source (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic slow,
    input  wire logic done,
    output logic      cfgClockTick
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] div_q;

    // Stall length is unknown, so ticks run on until done, not a fixed count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_q        <= 2'h0;
            cfgClockTick <= 1'b0;
        end else begin
            div_q        <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            cfgClockTick <= !done && (!slow || div_q == 2'h2);
        end
    end
endmodule : cfg_clock_source

// ==== dv/config_startup_sequencer_tb.sv ====
// Self-checking bench for the startup sequencer
module config_startup_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] NW = startup_seq_pkg::WAIT_SEL_NO_WAIT_OPTION;
    localparam logic [3:0] WD = startup_seq_pkg::WE_SEL_DEFAULT;

    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       configLoaded = 1'b0;
    logic       cfgClockTick;
    logic       slow = 1'b0;
    logic [3:0] weSel = WD;
    logic [3:0] lockSel = NW;
    logic [3:0] matchSel = NW;
    logic       calIo = 1'b0;
    logic       locked = 1'b0;
    logic       matched = 1'b0;
    logic [2:0] phase;
    logic       gwe;
    logic       bramEn;
    logic       done;
    logic       stalled;
    int         nMismatch = 0;
    int         checksDone = 0;
    int         cycles = 0;

    always #12.5 mclk = ~mclk;

    config_startup_sequencer i_config_startup_sequencer (
        .mclk(mclk), .resetn(resetn), .configLoaded(configLoaded),
        .cfgClockTick(cfgClockTick), .writeEnablePhaseSelect(weSel),
        .lockWaitPhaseSelect(lockSel), .matchWaitPhaseSelect(matchSel),
        .donePhaseSelect(3'h6), .usesCalibratedIo(calIo),
        .allClocksLocked(locked), .impedanceCalibrationMatched(matched),
        .startupPhase(phase), .globalWriteEnable(gwe),
        .blockRamEnable(bramEn), .done(done), .stalled(stalled));

    cfg_clock_source i_cfg_clock_source (
        .mclk(mclk), .resetn(resetn), .slow(slow), .done(done),
        .cfgClockTick(cfgClockTick));

    task automatic chk(input string what, input logic [2:0] exp,
                       input logic [2:0] got);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic start(input logic [3:0] we, input logic [3:0] lk,
                         input logic [3:0] mt, input logic cal,
                         input logic sl);
        @(posedge mclk);
        resetn <= 1'b0;
        configLoaded <= 1'b0;
        locked <= 1'b0;
        matched <= 1'b0;
        weSel <= we;
        lockSel <= lk;
        matchSel <= mt;
        calIo <= cal;
        slow <= sl;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        configLoaded <= 1'b1;
    endtask : start

    task automatic toPhase(input logic [2:0] p);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (phase !== p && n < 200);
        chk("phase", p, phase);
    endtask : toPhase

    // Long hold proves ticks are ignored while the wait is unmet
    task automatic holdAt(input logic [2:0] p);
        toPhase(p);
        repeat (12) @(negedge mclk);
        chk("held phase", p, phase);
        chk("stalled", 3'h1, {2'h0, stalled});
    endtask : holdAt

    task automatic scDefault;
        start(WD, NW, NW, 1'b0, 1'b0);
        toPhase(3'h1);
        for (int p = 2; p <= 6; p++) begin
            @(negedge mclk);
            chk("step", 3'(p), phase);
            chk("bram", 3'h0, {2'h0, bramEn});
            chk("not stalled", 3'h0, {2'h0, stalled});
        end
        chk("gwe early", 3'h0, {2'h0, gwe});
        @(negedge mclk);
        chk("gwe", 3'h1, {2'h0, gwe});
        chk("bram", 3'h1, {2'h0, bramEn});
    endtask : scDefault

    task automatic scLock;
        start(WD, 4'h3, NW, 1'b0, 1'b1);
        holdAt(3'h3);
        @(posedge mclk);
        locked <= 1'b1;
        toPhase(3'h4);
    endtask : scLock

    task automatic scMatch;
        start(WD, NW, 4'h5, 1'b0, 1'b0);
        holdAt(3'h5);
        chk("gwe", 3'h0, {2'h0, gwe});
        @(posedge mclk);
        matched <= 1'b1;
        toPhase(3'h6);
    endtask : scMatch

    task automatic scAuto;
        start(WD, NW, startup_seq_pkg::WAIT_SEL_AUTO, 1'b1, 1'b0);
        holdAt(3'h2);
        @(posedge mclk);
        matched <= 1'b1;
        toPhase(3'h3);
        start(WD, NW, startup_seq_pkg::WAIT_SEL_AUTO, 1'b0, 1'b0);
        toPhase(3'h2);
        chk("auto no stall", 3'h0, {2'h0, stalled});
        toPhase(3'h6);
    endtask : scAuto

    task automatic scKeep;
        start(startup_seq_pkg::WE_SEL_KEEP, NW, NW, 1'b0, 1'b0);
        toPhase(3'h6);
        repeat (4) @(negedge mclk);
        chk("done", 3'h1, {2'h0, done});
        chk("gwe keep", 3'h0, {2'h0, gwe});
        chk("bram keep", 3'h0, {2'h0, bramEn});
        start(startup_seq_pkg::WE_SEL_DONE, NW, NW, 1'b0, 1'b0);
        toPhase(3'h6);
        @(negedge mclk);
        chk("gwe at done", 3'h0, {2'h0, gwe});
        @(negedge mclk);
        chk("gwe after done", 3'h1, {2'h0, gwe});
    endtask : scKeep

    task automatic reportAndStop;
        $display("mismatches %0d checks %0d", nMismatch, checksDone);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : reportAndStop

    // Whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            reportAndStop();
        end
    end

    initial begin
        scDefault();
        scLock();
        scMatch();
        scAuto();
        scKeep();
        reportAndStop();
    end
endmodule : config_startup_sequencer_tb
